// file: hw/ssm_pkg.sv
// shared constants and types for the system-side serial mode controller
// assumes a single 50 MHz core clock and a synchronous active-low reset
package ssm_pkg;
   // startup mode selection encodings
   typedef enum logic [1:0] {
      SSM_START_10G = 2'h0,
      SSM_START_BX = 2'h1,
      SSM_START_SGMII = 2'h2,
      SSM_START_OFF = 2'h3
   } ssm_start_t;

   // negotiated line rate encodings
   typedef enum logic [1:0] {
      SSM_RATE_100M = 2'h0,
      SSM_RATE_1G = 2'h1,
      SSM_RATE_10G = 2'h2
   } ssm_rate_t;

   // active lane personality seen by the lanes
   typedef enum logic [2:0] {
      SSM_LM_OFF = 3'h0,
      SSM_LM_KR = 3'h1,
      SSM_LM_BX = 3'h2,
      SSM_LM_SG1G = 3'h3,
      SSM_LM_SG100 = 3'h4
   } ssm_lane_mode_t;

   // transmit content toward the system side
   typedef enum logic [1:0] {
      SSM_TX_QUIET = 2'h0,
      SSM_TX_IDLE = 2'h1,
      SSM_TX_LFAULT = 2'h2,
      SSM_TX_DATA = 2'h3
   } ssm_tx_t;

   // lane rates per physical lane; the top rate is in kb/s since it is not a whole Mb/s
   localparam int SSM_RATE_1G25_MBPS = 1250;
   localparam int SSM_RATE_3G125_MBPS = 3125;
   localparam int SSM_RATE_10G3125_KBPS = 10312500;

   // timing
   localparam int SSM_CLK_MHZ = 50;
   localparam int SSM_LBREAK_US = 100;
   localparam int SSM_LBREAK_CYC = SSM_LBREAK_US * SSM_CLK_MHZ;
   localparam int SSM_LFAULT_CYC = 16;

   // lane numbering
   localparam int SSM_SGMII_LANE = 0;
   localparam int SSM_KR_LANE = 2;
   localparam int SSM_NUM_LANES = 4;
endpackage : ssm_pkg

// file: hw/ssm_sync2.sv
// two-flip-flop synchroniser for a vector of level inputs
// assumes the inputs come from outside the core clock domain
`timescale 1ns/1ps
`default_nettype none
module ssm_sync2 #(
   parameter int W = 1
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } ssm_sync_state_t;

   ssm_sync_state_t st;
   ssm_sync_state_t next_st;

   // first stage feeds only the second
   always_comb begin
      next_st.meta = async_in;
      next_st.stable = st.meta;
      if (!rst_n) begin
         next_st = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      st <= next_st;
   end

   assign sync_out = st.stable;
endmodule : ssm_sync2
`default_nettype wire

// file: hw/ssm_ctrl.sv
// system-side serial mode controller: startup mode, rate follow, link loss
// assumes line-side status pins are asynchronous; partner acks are core-clock pulses
`timescale 1ns/1ps
`default_nettype none
module ssm_ctrl #(
   parameter int LBREAK_CYC = ssm_pkg::SSM_LBREAK_CYC,
   parameter int LFAULT_CYC = ssm_pkg::SSM_LFAULT_CYC
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [1:0] start_mode,
   input wire logic line_link_up,
   input wire logic [1:0] line_rate,
   input wire logic serdes_sync,
   input wire logic sgmii_ack,
   output logic [2:0] lane_mode,
   output logic [3:0] lane_en,
   output logic [12:0] lane0_rate_mbps,
   output logic [1:0] tx_content,
   output logic sgmii_msg_valid,
   output logic sgmii_msg_link,
   output logic [1:0] sgmii_msg_rate,
   output logic sgmii_cores_on,
   output logic kr_cores_on,
   output logic an_restart,
   output logic an_done_irq
);
   // ------------------------------------------------------------
   // parameter checks
   // ------------------------------------------------------------
   // both timers share the 24-bit cycle counter
   if (LBREAK_CYC < 1 || LFAULT_CYC < 1 || LBREAK_CYC > 32'h00FF_FFFF || LFAULT_CYC > 32'h00FF_FFFF) begin : g_bad_timer
      $error("ssm_ctrl: bad timer parameter");
   end

   typedef enum {
      S_BOOT,
      S_WAIT,
      S_DOWN_MSG,
      S_UP_MSG,
      S_RUN,
      S_FAULT,
      S_BREAK
   } ssm_fsm_t;

   typedef struct packed {
      ssm_fsm_t fsm;
      ssm_pkg::ssm_lane_mode_t lm;
      ssm_pkg::ssm_tx_t tx;
      logic [3:0] en;
      logic [12:0] l0rate;
      logic msg_v;
      logic msg_link;
      logic [1:0] msg_rate;
      logic sg_on;
      logic kr_on;
      logic an_rs;
      logic irq;
      logic [23:0] cnt;
   } ssm_state_t;

   ssm_state_t st;
   ssm_state_t next_st;
   logic [1:0] sync_rate;
   logic sync_link;
   logic sync_lock;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   ssm_sync2 #(.W(4)) u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .async_in({line_link_up, serdes_sync, line_rate}),
      .sync_out({sync_link, sync_lock, sync_rate})
   );

   // idle personality for the chosen startup mode
   function automatic ssm_pkg::ssm_lane_mode_t home_mode(input logic [1:0] sm);
      unique case (ssm_pkg::ssm_start_t'(sm))
         ssm_pkg::SSM_START_10G: home_mode = ssm_pkg::SSM_LM_KR;
         ssm_pkg::SSM_START_BX: home_mode = ssm_pkg::SSM_LM_BX;
         ssm_pkg::SSM_START_SGMII: home_mode = ssm_pkg::SSM_LM_SG1G;
         ssm_pkg::SSM_START_OFF: home_mode = ssm_pkg::SSM_LM_OFF;
      endcase
   endfunction : home_mode

   // personality after link up, by negotiated rate and startup mode
   function automatic ssm_pkg::ssm_lane_mode_t rate_mode(input logic [1:0] sm, input logic [1:0] r);
      if (r == ssm_pkg::SSM_RATE_10G) begin
         rate_mode = ssm_pkg::SSM_LM_KR;
      end else if (r == ssm_pkg::SSM_RATE_100M) begin
         rate_mode = ssm_pkg::SSM_LM_SG100;
      end else if (ssm_pkg::ssm_start_t'(sm) == ssm_pkg::SSM_START_SGMII) begin
         rate_mode = ssm_pkg::SSM_LM_SG1G;
      end else begin
         rate_mode = ssm_pkg::SSM_LM_BX;
      end
   endfunction : rate_mode

   // ------------------------------------------------------------
   // mode sequencer
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.an_rs = 1'b0;
      next_st.irq = 1'b0;
      next_st.msg_v = 1'b0;
      unique case (st.fsm)
         // first cycle out of reset; SGMII startup opens with a link-down exchange
         S_BOOT: begin
            next_st.lm = home_mode(start_mode);
            if (ssm_pkg::ssm_start_t'(start_mode) == ssm_pkg::SSM_START_SGMII) begin
               next_st.fsm = S_DOWN_MSG;
            end else begin
               next_st.fsm = S_WAIT;
            end
         end
         S_WAIT: begin
            next_st.lm = home_mode(start_mode);
            if (sync_link) begin
               next_st.irq = 1'b1;
               if (ssm_pkg::ssm_start_t'(start_mode) == ssm_pkg::SSM_START_SGMII) begin
                  next_st.fsm = S_UP_MSG;
                  next_st.msg_rate = sync_rate;
               end else begin
                  next_st.lm = rate_mode(start_mode, sync_rate);
                  next_st.fsm = S_RUN;
               end
            end
         end
         S_DOWN_MSG: begin
            next_st.msg_v = 1'b1;
            next_st.msg_link = 1'b0;
            // an ack only counts while the message is on the wire
            if (sgmii_ack && st.msg_v) begin
               next_st.msg_v = 1'b0;
               next_st.fsm = S_WAIT;
            end
         end
         S_UP_MSG: begin
            next_st.msg_v = 1'b1;
            next_st.msg_link = 1'b1;
            if (sgmii_ack && st.msg_v) begin
               next_st.msg_v = 1'b0;
               next_st.lm = rate_mode(start_mode, st.msg_rate);
               next_st.fsm = S_RUN;
            end else if (!sync_link) begin
               next_st.msg_v = 1'b0;
               next_st.fsm = S_BREAK;
               next_st.cnt = '0;
            end
         end
         S_RUN: begin
            if (!sync_link) begin
               next_st.cnt = '0;
               if (st.lm == ssm_pkg::SSM_LM_KR) begin
                  next_st.fsm = S_FAULT;
               end else begin
                  next_st.fsm = S_BREAK;
               end
            end
         end
         S_FAULT: begin
            next_st.cnt = st.cnt + 24'h00_0001;
            if (st.cnt == 24'(LFAULT_CYC - 1)) begin
               next_st.cnt = '0;
               next_st.fsm = S_BREAK;
            end
         end
         S_BREAK: begin
            // 1G SGMII keeps running; others go home
            if (st.lm != ssm_pkg::SSM_LM_SG1G) begin
               next_st.lm = home_mode(start_mode);
            end
            next_st.cnt = st.cnt + 24'h00_0001;
            if (st.cnt == 24'(LBREAK_CYC - 1)) begin
               next_st.cnt = '0;
               next_st.an_rs = 1'b1;
               if (ssm_pkg::ssm_start_t'(start_mode) == ssm_pkg::SSM_START_SGMII) begin
                  next_st.fsm = S_DOWN_MSG;
               end else begin
                  next_st.fsm = S_WAIT;
               end
            end
         end
      endcase

      // data only when running and locked; faults in the fault hold and while waiting at 10G, quiet when off, else idles
      if (next_st.fsm == S_FAULT || (next_st.fsm == S_WAIT && next_st.lm == ssm_pkg::SSM_LM_KR)) begin
         next_st.tx = ssm_pkg::SSM_TX_LFAULT;
      end else if (next_st.lm == ssm_pkg::SSM_LM_OFF) begin
         next_st.tx = ssm_pkg::SSM_TX_QUIET;
      end else if (next_st.fsm == S_RUN && sync_lock) begin
         next_st.tx = ssm_pkg::SSM_TX_DATA;
      end else begin
         next_st.tx = ssm_pkg::SSM_TX_IDLE;
      end

      // core and lane mapping; lanes 1 and 3 never used here
      next_st.sg_on = next_st.lm inside {ssm_pkg::SSM_LM_BX, ssm_pkg::SSM_LM_SG1G, ssm_pkg::SSM_LM_SG100};
      next_st.kr_on = next_st.lm == ssm_pkg::SSM_LM_KR;
      next_st.en = '0;
      next_st.en[ssm_pkg::SSM_SGMII_LANE] = next_st.sg_on;
      next_st.en[ssm_pkg::SSM_KR_LANE] = next_st.kr_on;
      // lane zero runs 1.25 Gb/s for SGMII
      next_st.l0rate = next_st.sg_on ? 13'(ssm_pkg::SSM_RATE_1G25_MBPS) : '0;

      // registered reset state, home mode 10G default
      if (!rst_n) begin
         next_st = '0;
         next_st.fsm = S_BOOT;
         next_st.lm = ssm_pkg::SSM_LM_KR;
         next_st.tx = ssm_pkg::SSM_TX_LFAULT;
         next_st.kr_on = 1'b1;
         next_st.en[ssm_pkg::SSM_KR_LANE] = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      st <= next_st;
   end

   // outputs straight from state flops
   assign lane_mode = st.lm;
   assign lane_en = st.en;
   assign lane0_rate_mbps = st.l0rate;
   assign tx_content = st.tx;
   assign sgmii_msg_valid = st.msg_v;
   assign sgmii_msg_link = st.msg_link;
   assign sgmii_msg_rate = st.msg_rate;
   assign sgmii_cores_on = st.sg_on;
   assign kr_cores_on = st.kr_on;
   assign an_restart = st.an_rs;
   assign an_done_irq = st.irq;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_fault_first;
      @(posedge core_clk) disable iff (!rst_n)
         (st.fsm == S_RUN && st.lm == ssm_pkg::SSM_LM_KR && !sync_link) |=> tx_content == ssm_pkg::SSM_TX_LFAULT;
   endproperty
   a_fault_first: assert property (p_fault_first) else $error("no fault at 10G loss");

   property p_data_lock;
      @(posedge core_clk) disable iff (!rst_n)
         tx_content == ssm_pkg::SSM_TX_DATA |-> $past(sync_lock);
   endproperty
   a_data_lock: assert property (p_data_lock) else $error("data before sync");

   property p_restart_after_break;
      @(posedge core_clk) disable iff (!rst_n)
         $rose(an_restart) |-> $past(st.fsm) == S_BREAK && $past(st.cnt) == 24'(LBREAK_CYC - 1);
   endproperty
   a_restart_after_break: assert property (p_restart_after_break) else $error("early restart");

   property p_kr_lane2;
      @(posedge core_clk) disable iff (!rst_n)
         kr_cores_on |-> lane_en[ssm_pkg::SSM_KR_LANE] && !lane_en[1] && !lane_en[3];
   endproperty
   a_kr_lane2: assert property (p_kr_lane2) else $error("KR off lane two");

   property p_sg_lane0;
      @(posedge core_clk) disable iff (!rst_n)
         sgmii_cores_on |-> lane_en[ssm_pkg::SSM_SGMII_LANE] && lane0_rate_mbps == 13'(ssm_pkg::SSM_RATE_1G25_MBPS);
   endproperty
   a_sg_lane0: assert property (p_sg_lane0) else $error("SGMII not on lane zero");

   property p_off_quiet;
      @(posedge core_clk) disable iff (!rst_n)
         (lane_mode == ssm_pkg::SSM_LM_OFF) |-> tx_content == ssm_pkg::SSM_TX_QUIET && lane_en == 4'h0;
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("off mode drives");

   sequence s_up_msg;
      sgmii_msg_valid && sgmii_msg_link;
   endsequence
   property p_up_ack;
      @(posedge core_clk) disable iff (!rst_n)
         s_up_msg ##0 (sgmii_ack && sync_link) |=> !sgmii_msg_valid && st.fsm == S_RUN;
   endproperty
   a_up_ack: assert property (p_up_ack) else $error("link-up ack not taken");

   property p_irq_pulse;
      @(posedge core_clk) disable iff (!rst_n)
         an_done_irq |=> !an_done_irq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq not a pulse");
endmodule : ssm_ctrl
`default_nettype wire

// file: testbench/ssm_mac_model.sv
// system-side mac model: answers sgmii auto-negotiation messages
// assumes messages are core-clock levels held until acknowledged
`timescale 1ns/1ps
`default_nettype none
module ssm_mac_model (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic sgmii_msg_valid,
   input wire logic stray_ack,
   input wire logic [2:0] ack_delay,
   output logic sgmii_ack
);
   logic ack_r;
   logic [2:0] cnt;

   // -------------------------------------------------------------
   // acknowledge engine
   // -------------------------------------------------------------
   // partner acknowledges messages
   // one pulse per message; the pending message is still seen at the ack edge, so skip it
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
         cnt <= 3'h0;
      end else begin
         ack_r <= 1'b0;
         if (sgmii_msg_valid && !ack_r) begin
            if (cnt >= ack_delay) begin
               ack_r <= 1'b1;
               cnt <= 3'h0;
            end else begin
               cnt <= cnt + 3'h1;
            end
         end else begin
            cnt <= 3'h0;
         end
      end
   end

   // stray pulses only when the bench asks for one
   assign sgmii_ack = ack_r | stray_ack;
endmodule : ssm_mac_model
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the system-side serial mode controller
// assumes the mac model answers messages; inputs change at the falling edge
`timescale 1ns/1ps
`default_nettype none
`define SSM_CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module testbench;
   localparam int LB = 8;
   localparam int LF = 2;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] start_mode = 2'h0;
   logic line_link_up = 1'b0;
   logic [1:0] line_rate = 2'h0;
   logic serdes_sync = 1'b0;
   logic stray_ack = 1'b0;
   logic [2:0] ack_delay = 3'h0;
   logic sgmii_ack;
   logic [2:0] lane_mode;
   logic [3:0] lane_en;
   logic [12:0] lane0_rate_mbps;
   logic [1:0] tx_content;
   logic sgmii_msg_valid, sgmii_msg_link, sgmii_cores_on, kr_cores_on, an_restart, an_done_irq;
   logic [1:0] sgmii_msg_rate;
   int error_cnt = 0;
   int num_checks = 0;

   always #10 core_clk = ~core_clk;

   ssm_ctrl #(.LBREAK_CYC(LB), .LFAULT_CYC(LF)) uut (.core_clk(core_clk), .rst_n(rst_n),
      .start_mode(start_mode), .line_link_up(line_link_up), .line_rate(line_rate),
      .serdes_sync(serdes_sync), .sgmii_ack(sgmii_ack), .lane_mode(lane_mode), .lane_en(lane_en),
      .lane0_rate_mbps(lane0_rate_mbps), .tx_content(tx_content), .sgmii_msg_valid(sgmii_msg_valid),
      .sgmii_msg_link(sgmii_msg_link), .sgmii_msg_rate(sgmii_msg_rate), .sgmii_cores_on(sgmii_cores_on),
      .kr_cores_on(kr_cores_on), .an_restart(an_restart), .an_done_irq(an_done_irq));

   ssm_mac_model mac (.core_clk(core_clk), .rst_n(rst_n), .sgmii_msg_valid(sgmii_msg_valid),
      .stray_ack(stray_ack), .ack_delay(ack_delay), .sgmii_ack(sgmii_ack));

   // -------------------------------------------------------------
   // expectations
   // -------------------------------------------------------------
   function automatic logic [2:0] home_lm(input logic [1:0] sm);
      case (sm)
         2'h0: return ssm_pkg::SSM_LM_KR;
         2'h1: return ssm_pkg::SSM_LM_BX;
         2'h2: return ssm_pkg::SSM_LM_SG1G;
         default: return ssm_pkg::SSM_LM_OFF;
      endcase
   endfunction : home_lm

   // 1G outside sgmii startup lands on 1000base-x
   function automatic logic [2:0] link_lm(input logic [1:0] sm, input logic [1:0] rt);
      if (rt == ssm_pkg::SSM_RATE_10G) return ssm_pkg::SSM_LM_KR;
      if (rt == ssm_pkg::SSM_RATE_100M) return ssm_pkg::SSM_LM_SG100;
      return (sm == ssm_pkg::SSM_START_SGMII) ? ssm_pkg::SSM_LM_SG1G : ssm_pkg::SSM_LM_BX;
   endfunction : link_lm

   function automatic logic [3:0] en_of(input logic [2:0] lm);
      if (lm == ssm_pkg::SSM_LM_KR) return 4'h4;
      return (lm == ssm_pkg::SSM_LM_OFF) ? 4'h0 : 4'h1;
   endfunction : en_of

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out

   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask : cyc

   // bounded wait on irq, message or message end
   task automatic wait_hi(input int sel, input int lim);
      int i;
      for (i = 0; i < lim; i++) begin
         @(negedge core_clk);
         if ((sel == 0 && an_done_irq === 1'b1) || (sel == 1 && sgmii_msg_valid === 1'b1) ||
             (sel == 2 && sgmii_msg_valid === 1'b0)) return;
      end
      error_cnt++;
      $display("[FAIL] wait %0d expired", sel);
      close_out();
   endtask : wait_hi

   task automatic chk_mode(input logic [2:0] lm);
      `SSM_CHK("lane_mode", lm, lane_mode)
      `SSM_CHK("lane_en", en_of(lm), lane_en)
      `SSM_CHK("lane0_rate", (en_of(lm) == 4'h1) ? 13'h04e2 : 13'h0000, lane0_rate_mbps)
      `SSM_CHK("kr_cores", lm == ssm_pkg::SSM_LM_KR, kr_cores_on)
      `SSM_CHK("sgmii_cores", en_of(lm) == 4'h1, sgmii_cores_on)
   endtask : chk_mode

   task automatic chk_home(input logic [1:0] sm);
      chk_mode(home_lm(sm));
      `SSM_CHK("home_tx", 1'b1, (sm == 2'h0) ? (tx_content === 2'h1 || tx_content === 2'h2) :
         (sm == 2'h3) ? tx_content === 2'h0 : tx_content === 2'h1)
   endtask : chk_home

   // -------------------------------------------------------------
   // one startup mode, one link-up rate, one link loss
   // -------------------------------------------------------------
   task automatic run_case(input logic [1:0] sm, input logic [1:0] rt);
      logic [2:0] lm;
      int n;
      bit flt;
      bit moved;
      lm = link_lm(sm, rt);
      flt = 0;
      moved = 0;
      start_mode = sm;
      line_link_up = 1'b0;
      serdes_sync = 1'b0;
      ack_delay = 3'($urandom_range(0, 5));
      rst_n = 1'b0;
      cyc(2);
      rst_n = 1'b1;
      cyc(2);
      // sgmii startup opens with a link-down message; the other modes stay silent
      `SSM_CHK("boot_down_msg", sm == ssm_pkg::SSM_START_SGMII, sgmii_msg_valid)
      `SSM_CHK("boot_down_link", 1'b0, sgmii_msg_link)
      wait_hi(2, 20);
      cyc(4);
      chk_home(sm);
      // unsolicited acknowledge must be ignored
      stray_ack = 1'b1;
      cyc(1);
      stray_ack = 1'b0;
      cyc(2);
      `SSM_CHK("stray_msg", 1'b0, sgmii_msg_valid)
      line_rate = rt;
      line_link_up = 1'b1;
      wait_hi(0, 10);
      if (sm == ssm_pkg::SSM_START_SGMII) begin
         wait_hi(1, 4);
         `SSM_CHK("up_msg_link", 1'b1, sgmii_msg_link)
         `SSM_CHK("up_msg_rate", rt, sgmii_msg_rate)
         wait_hi(2, 20);
      end
      cyc(2);
      chk_mode(lm);
      `SSM_CHK("tx_unsynced", 1'b0, tx_content === ssm_pkg::SSM_TX_DATA)
      serdes_sync = 1'b1;
      cyc(5);
      `SSM_CHK("tx_synced", ssm_pkg::SSM_TX_DATA, tx_content)
      line_link_up = 1'b0;
      serdes_sync = (lm == ssm_pkg::SSM_LM_SG1G);
      for (n = 0; n < LF + LB + 40; n++) begin
         @(negedge core_clk);
         if (tx_content === ssm_pkg::SSM_TX_LFAULT) flt = 1;
         if (lane_mode !== lm) moved = 1;
         if (an_restart === 1'b1) break;
      end
      `SSM_CHK("restart_seen", 1'b1, an_restart)
      // two sync edges, the fault hold when at 10G, then the whole break timer
      `SSM_CHK("break_wait", ((lm == ssm_pkg::SSM_LM_KR) ? LF : 0) + LB + 2, n)
      if (lm == ssm_pkg::SSM_LM_KR) `SSM_CHK("loss_fault", 1'b1, flt)
      if (sm != 2'h0 && lm != ssm_pkg::SSM_LM_KR) `SSM_CHK("no_fault", 1'b0, flt)
      if (lm == ssm_pkg::SSM_LM_SG1G) `SSM_CHK("sg1g_kept", 1'b0, moved)
      if (sm == ssm_pkg::SSM_START_SGMII) begin
         wait_hi(1, 10);
         `SSM_CHK("down_msg_link", 1'b0, sgmii_msg_link)
         wait_hi(2, 20);
      end
      cyc(2);
      chk_home(sm);
      $display("case start %0d rate %0d done", sm, rt);
   endtask : run_case

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      void'($urandom(32'h0c4b81d6));
      cyc(6);
      `SSM_CHK("rst_mode", ssm_pkg::SSM_LM_KR, lane_mode)
      `SSM_CHK("rst_lanes", 4'h4, lane_en)
      `SSM_CHK("rst_tx", ssm_pkg::SSM_TX_LFAULT, tx_content)
      rst_n = 1'b1;
      cyc(2);
      `SSM_CHK("rel_tx", ssm_pkg::SSM_TX_LFAULT, tx_content)
      for (int s = 0; s < 4; s++) begin
         for (int r = 0; r < 3; r++) run_case(2'(s), 2'(r));
      end
      repeat (6) run_case(2'($urandom_range(0, 3)), 2'($urandom_range(0, 2)));
      close_out();
   end

   // hang guard
   initial begin
      #1000000;
      error_cnt++;
      close_out();
   end
endmodule : testbench
`undef SSM_CHK
`default_nettype wire
